// ==== hdl/cwu_pkg.sv ====
// How it works
// - Six modes: half-bridge, push-pull, async steer, sync steer, forward, reverse.
// - Every mode takes one data input and drives up to four outputs.
// - Auto-shutdown forces driven outputs inactive in every mode except non-steered outputs in steering modes, which keep their override level.
// - One output's turn-on may be delayed after its partner turns off.
// - Two separate 6-bit dead-band timers, rising and falling, each enabled separately.
// - Half-bridge: A follows input, B its inverse, with dead-band gap.
// - Mode code 100 selects half-bridge.
// - Steering selections do nothing in half-bridge mode.
// - Half-bridge: C and D mirror A and B with own polarity.
// - Push-pull: successive input pulses alternate between A and B.
// - Mode code 101 selects push-pull.
// - Push-pull sequencer resets while disabled or shut down.
// - After sequencer reset the first pulse appears on A.
// - Push-pull: C copies A, D copies B, each with own polarity.
// - Steering selections do nothing in push-pull mode.
// - Full-bridge: three outputs static, one follows the input.
// - Flipping the low mode bit swaps direction without disabling.
// - Every output has its own polarity control.
// - Forward (010): A active, B and C inactive, D modulated.
// - Reverse (011): C active, A and D inactive, B modulated.
package cwu_pkg;
    localparam int NUM_OUT = 4;
    localparam int NUM_SRC = 8;
    localparam int SHUT_N = 2;
    localparam int ISM_W = 3;
    localparam int DB_W = 6;
    localparam int ADDR_W = 8;

    localparam logic [2:0] MODE_ASTEER = 3'h0;
    localparam logic [2:0] MODE_SSTEER = 3'h1;
    localparam logic [2:0] MODE_FWD = 3'h2;
    localparam logic [2:0] MODE_REV = 3'h3;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_PUSH = 3'h5;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_OUTCFG = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DBAND = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SHUT = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h10;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int OUT_POL_LSB = 0;
    localparam int OUT_STR_LSB = 8;
    localparam int OUT_OVR_LSB = 16;
    localparam int OUT_ISM_LSB = 24;
    localparam int DB_RISE_LSB = 0;
    localparam int DB_FALL_LSB = 8;
    localparam int DB_RISE_EN_BIT = 16;
    localparam int DB_FALL_EN_BIT = 17;
    localparam int SHUT_STATE_BIT = 0;
    localparam int SHUT_RESTART_BIT = 1;
    localparam int SHUT_SRC_LSB = 4;

    localparam logic PP_INIT = 1'b1;
    localparam logic DIR_FWD = 1'b0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic valid;
    } cwu_ahb_req_t;

    typedef struct packed {
        logic [ISM_W-1:0] ism;
        logic [NUM_OUT-1:0] ovr;
        logic [NUM_OUT-1:0] str;
        logic [NUM_OUT-1:0] pol;
    } cwu_outcfg_t;
endpackage

// ==== hdl/cwu_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module cwu_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Levels from other domains
    input wire logic [W-1:0] async_in,
    // Filtered levels
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                    out_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= async_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // Accept a change only once the last two stages agree
                    if (s2_q[i] == s3_q[i]) begin
                        out_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign sync_out = out_q;
endmodule
`default_nettype wire

// ==== hdl/cwu_db_delay.sv ====
`timescale 1ns/1ps
`default_nettype none
module cwu_db_delay #(
    parameter int W = cwu_pkg::DB_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Timer setup
    input wire logic delay_en,
    input wire logic [W-1:0] delay_count,
    // Level path
    input wire logic level_in,
    output logic level_out
);
    logic [W-1:0] cnt_q;
    logic at_count;

    // Compare with >= so a count lowered while the level is high cannot wrap the timer
    assign at_count = (cnt_q >= delay_count);
    // Rising edge held back by delay_count cycles, falling edge passes at once
    assign level_out = level_in && (!delay_en || at_count);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (!level_in) begin
            cnt_q <= '0;
        end else if (!at_count) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/cwu_top.sv ====
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cwu_top #(
    parameter int DB_W = cwu_pkg::DB_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Data and fault sources
    input wire logic [cwu_pkg::NUM_SRC-1:0] data_sources,
    input wire logic [cwu_pkg::SHUT_N-1:0] shutdown_sources,
    // Drive outputs
    output logic drive_output_first,
    output logic drive_output_second,
    output logic drive_output_third,
    output logic drive_output_fourth
);
    localparam int NO = cwu_pkg::NUM_OUT;
    localparam int NS = cwu_pkg::NUM_SRC;
    localparam int SN = cwu_pkg::SHUT_N;

    // Bus front end
    cwu_pkg::cwu_ahb_req_t req_q;
    cwu_pkg::cwu_ahb_req_t req_d;
    logic take;
    logic wr;
    logic wr_ctrl;
    logic wr_outcfg;
    logic wr_dband;
    logic wr_shut;

    // Registers
    logic en_q;
    logic [2:0] mode_q;
    cwu_pkg::cwu_outcfg_t outcfg_q;
    logic [DB_W-1:0] rise_cnt_q;
    logic [DB_W-1:0] fall_cnt_q;
    logic rise_en_q;
    logic fall_en_q;
    logic shut_q;
    logic restart_q;
    logic [SN-1:0] shut_en_q;

    // Data path
    logic [NS+SN-1:0] sync_out;
    logic modulated_input_signal;
    logic data_n;
    logic [SN-1:0] shut_in;
    logic data_q;
    logic rise;
    logic hb_a;
    logic hb_b;
    logic pp_q;
    logic pp_eff;
    logic dir_q;
    logic dir_eff;
    logic fb_turn;
    logic [DB_W-1:0] hold_q;
    logic [DB_W-1:0] fb_load;
    logic fb_mod;
    logic [NO-1:0] str_sync_q;
    logic [NO-1:0] str_eff;
    logic [NO-1:0] act;
    logic [NO-1:0] out_d;
    logic [NO-1:0] out_q;
    logic is_pp;
    logic is_fb;
    logic is_steer;
    logic src_hit;
    logic shut_d;

    // Read data
    logic [31:0] rd_ctrl;
    logic [31:0] rd_outcfg;
    logic [31:0] rd_dband;
    logic [31:0] rd_shut;
    logic [31:0] rd_stat;

    assign take = hsel && htrans[1] && hready;
    assign req_d = '{addr: haddr[cwu_pkg::ADDR_W-1:0], write: hwrite, valid: take};
    assign wr = req_q.valid && req_q.write;
    assign wr_ctrl = wr && (req_q.addr == cwu_pkg::ADDR_CTRL);
    assign wr_outcfg = wr && (req_q.addr == cwu_pkg::ADDR_OUTCFG);
    assign wr_dband = wr && (req_q.addr == cwu_pkg::ADDR_DBAND);
    assign wr_shut = wr && (req_q.addr == cwu_pkg::ADDR_SHUT);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= '0;
        end else if (hready) begin
            req_q <= req_d;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            en_q <= 1'b0;
            mode_q <= cwu_pkg::MODE_ASTEER;
        end else if (wr_ctrl) begin
            en_q <= hwdata[cwu_pkg::CTRL_EN_BIT];
            // Mode is writable at any time; forward/reverse swaps apply live
            mode_q <= hwdata[cwu_pkg::CTRL_MODE_LSB +: 3];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            outcfg_q <= '0;
        end else if (wr_outcfg) begin
            outcfg_q.pol <= hwdata[cwu_pkg::OUT_POL_LSB +: NO];
            outcfg_q.str <= hwdata[cwu_pkg::OUT_STR_LSB +: NO];
            outcfg_q.ovr <= hwdata[cwu_pkg::OUT_OVR_LSB +: NO];
            outcfg_q.ism <= hwdata[cwu_pkg::OUT_ISM_LSB +: cwu_pkg::ISM_W];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rise_cnt_q <= '0;
            fall_cnt_q <= '0;
            rise_en_q <= 1'b0;
            fall_en_q <= 1'b0;
        end else if (wr_dband) begin
            rise_cnt_q <= hwdata[cwu_pkg::DB_RISE_LSB +: DB_W];
            fall_cnt_q <= hwdata[cwu_pkg::DB_FALL_LSB +: DB_W];
            rise_en_q <= hwdata[cwu_pkg::DB_RISE_EN_BIT];
            fall_en_q <= hwdata[cwu_pkg::DB_FALL_EN_BIT];
        end
    end

    // Shutdown: a source hit or a software set wins over any clear
    assign src_hit = |(shut_in & shut_en_q);
    assign shut_d = src_hit || (wr_shut && hwdata[cwu_pkg::SHUT_STATE_BIT])
        || (shut_q && !(wr_shut && !hwdata[cwu_pkg::SHUT_STATE_BIT])
        && !restart_q);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shut_q <= 1'b0;
            restart_q <= 1'b0;
            shut_en_q <= '0;
        end else begin
            shut_q <= shut_d;
            if (wr_shut) begin
                restart_q <= hwdata[cwu_pkg::SHUT_RESTART_BIT];
                shut_en_q <= hwdata[cwu_pkg::SHUT_SRC_LSB +: SN];
            end
        end
    end

    // Input selection and edge detect
    cwu_sync3 #(.W(NS + SN)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in({shutdown_sources, data_sources}),
        .sync_out(sync_out)
    );

    assign modulated_input_signal = sync_out[outcfg_q.ism];
    assign shut_in = sync_out[NS +: SN];
    assign data_n = !modulated_input_signal;
    assign rise = modulated_input_signal && !data_q;
    assign is_pp = (mode_q == cwu_pkg::MODE_PUSH);
    assign is_fb = (mode_q == cwu_pkg::MODE_FWD) || (mode_q == cwu_pkg::MODE_REV);
    assign is_steer = (mode_q == cwu_pkg::MODE_ASTEER)
        || (mode_q == cwu_pkg::MODE_SSTEER);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_q <= 1'b0;
        end else begin
            data_q <= modulated_input_signal;
        end
    end

    // Half-bridge dead band
    cwu_db_delay #(.W(DB_W)) u_db_rise (
        .clock(clock),
        .reset_n(reset_n),
        .delay_en(rise_en_q),
        .delay_count(rise_cnt_q),
        .level_in(modulated_input_signal),
        .level_out(hb_a)
    );

    cwu_db_delay #(.W(DB_W)) u_db_fall (
        .clock(clock),
        .reset_n(reset_n),
        .delay_en(fall_en_q),
        .delay_count(fall_cnt_q),
        .level_in(data_n),
        .level_out(hb_b)
    );

    // Push-pull sequencer
    assign pp_eff = rise ? !pp_q : pp_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pp_q <= cwu_pkg::PP_INIT;
        end else if (!en_q || shut_q) begin
            pp_q <= cwu_pkg::PP_INIT;
        end else if (rise && is_pp) begin
            pp_q <= !pp_q;
        end
    end

    // Full-bridge direction, follows the mode while disabled, else changed only at a rising input edge
    assign fb_turn = is_fb && rise && (mode_q[0] != dir_q);
    assign dir_eff = (is_fb && rise) ? mode_q[0] : dir_q;
    assign fb_load = (mode_q[0] == cwu_pkg::DIR_FWD) ? (fall_en_q ? fall_cnt_q : '0)
        : (rise_en_q ? rise_cnt_q : '0);
    assign fb_mod = modulated_input_signal && (hold_q == '0)
        && !(fb_turn && (fb_load != '0));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dir_q <= cwu_pkg::DIR_FWD;
            hold_q <= '0;
        end else if (!en_q) begin
            dir_q <= wr_ctrl ? hwdata[cwu_pkg::CTRL_MODE_LSB] : mode_q[0];
            hold_q <= '0;
        end else begin
            if (is_fb && rise) begin
                dir_q <= mode_q[0];
            end
            if (fb_turn) begin
                hold_q <= fb_load;
            end else if (hold_q != '0) begin
                hold_q <= hold_q - 1'b1;
            end
        end
    end

    // Steering selections, latched at rising edges in synchronous mode
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            str_sync_q <= '0;
        end else if (rise) begin
            str_sync_q <= outcfg_q.str;
        end
    end

    assign str_eff = (mode_q == cwu_pkg::MODE_SSTEER && !rise) ? str_sync_q : outcfg_q.str;

    // Active-high drive per mode, before polarity
    always_comb begin
        act = '0;
        unique case (mode_q)
            cwu_pkg::MODE_HALF: begin
                act = {hb_b, hb_a, hb_b, hb_a};
            end
            cwu_pkg::MODE_PUSH: begin
                act[0] = modulated_input_signal && !pp_eff;
                act[1] = modulated_input_signal && pp_eff;
                act[2] = act[0];
                act[3] = act[1];
            end
            cwu_pkg::MODE_FWD, cwu_pkg::MODE_REV: begin
                if (dir_eff == cwu_pkg::DIR_FWD) begin
                    act = {fb_mod, 1'b0, 1'b0, 1'b1};
                end else begin
                    act = {1'b0, 1'b1, fb_mod, 1'b0};
                end
            end
            cwu_pkg::MODE_ASTEER, cwu_pkg::MODE_SSTEER: begin
                act = {NO{modulated_input_signal}};
            end
            default: begin
                act = '0;
            end
        endcase
    end

    // Output stage: steering only counts in steering modes
    genvar i;
    generate
        for (i = 0; i < NO; i++) begin : g_out
            assign out_d[i] = !en_q ? outcfg_q.pol[i]
                : (is_steer && !str_eff[i]) ? outcfg_q.ovr[i]
                : shut_q ? outcfg_q.pol[i]
                : (act[i] ^ outcfg_q.pol[i]);
        end
    endgenerate

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign drive_output_first = out_q[0];
    assign drive_output_second = out_q[1];
    assign drive_output_third = out_q[2];
    assign drive_output_fourth = out_q[3];

    // Register read-back
    assign rd_ctrl = 32'(en_q) | (32'(mode_q) << cwu_pkg::CTRL_MODE_LSB);
    assign rd_outcfg = (32'(outcfg_q.pol) << cwu_pkg::OUT_POL_LSB)
        | (32'(outcfg_q.str) << cwu_pkg::OUT_STR_LSB)
        | (32'(outcfg_q.ovr) << cwu_pkg::OUT_OVR_LSB)
        | (32'(outcfg_q.ism) << cwu_pkg::OUT_ISM_LSB);
    assign rd_dband = (32'(rise_cnt_q) << cwu_pkg::DB_RISE_LSB)
        | (32'(fall_cnt_q) << cwu_pkg::DB_FALL_LSB)
        | (32'(rise_en_q) << cwu_pkg::DB_RISE_EN_BIT)
        | (32'(fall_en_q) << cwu_pkg::DB_FALL_EN_BIT);
    assign rd_shut = (32'(shut_q) << cwu_pkg::SHUT_STATE_BIT)
        | (32'(restart_q) << cwu_pkg::SHUT_RESTART_BIT)
        | (32'(shut_en_q) << cwu_pkg::SHUT_SRC_LSB);
    assign rd_stat = {25'h0, dir_q, modulated_input_signal, pp_q, out_q};
    assign hrdata = !(req_q.valid && !req_q.write) ? 32'h0
        : (req_q.addr == cwu_pkg::ADDR_CTRL) ? rd_ctrl
        : (req_q.addr == cwu_pkg::ADDR_OUTCFG) ? rd_outcfg
        : (req_q.addr == cwu_pkg::ADDR_DBAND) ? rd_dband
        : (req_q.addr == cwu_pkg::ADDR_SHUT) ? rd_shut
        : (req_q.addr == cwu_pkg::ADDR_STAT) ? rd_stat
        : 32'h0;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    chk_off_inactive: assert property (!en_q |=> out_q == $past(outcfg_q.pol))
        else $error("disabled outputs not inactive");
    chk_shut_inactive: assert property (
        en_q && shut_q && !is_steer |=> out_q == $past(outcfg_q.pol))
        else $error("shutdown left an output driven");
    chk_half_gap: assert property (
        en_q && mode_q == cwu_pkg::MODE_HALF |=> ((out_q ^ $past(outcfg_q.pol)) & 4'h3) != 4'h3)
        else $error("half-bridge outputs overlap");
    chk_db_hold: assert property (
        $rose(modulated_input_signal) && rise_en_q && rise_cnt_q != '0 |-> !hb_a)
        else $error("rising dead band skipped");
    chk_pp_first: assert property (
        en_q && !shut_q && is_pp && rise && pp_q == cwu_pkg::PP_INIT
        |-> act[0] && !act[1])
        else $error("first push-pull pulse not on first output");
    chk_pp_alt: assert property (
        en_q && !shut_q && is_pp && rise |=> pp_q != $past(pp_q))
        else $error("push-pull did not alternate");
    chk_pp_clear: assert property (!en_q || shut_q |=> pp_q == cwu_pkg::PP_INIT)
        else $error("push-pull sequencer not reset");
    chk_fwd_levels: assert property (
        en_q && !shut_q && is_fb && dir_eff == cwu_pkg::DIR_FWD
        |=> ((out_q ^ $past(outcfg_q.pol)) & 4'h7) == 4'h1)
        else $error("forward static levels wrong");
    chk_rev_levels: assert property (
        en_q && !shut_q && is_fb && dir_eff != cwu_pkg::DIR_FWD
        |=> ((out_q ^ $past(outcfg_q.pol)) & 4'hd) == 4'h4)
        else $error("reverse static levels wrong");
    chk_fb_dir: assert property (
        en_q && is_fb && rise |=> dir_q == $past(mode_q[0]))
        else $error("direction not taken at rising edge");
endmodule
`default_nettype wire

// ==== verif/cwu_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cwu_switch_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Gate drives from the generator, A to D
    input wire logic gate_a,
    input wire logic gate_b,
    input wire logic gate_c,
    input wire logic gate_d,
    // Per-output inversion, bit 0 for A
    input wire logic [3:0] active_low,
    // Cycles in which both switches of one leg conduct
    output logic [15:0] overlaps
);
    wire logic [3:0] on_w;
    wire logic shoot_w;

    // Switches conduct at the active level after polarity
    assign on_w = {gate_d, gate_c, gate_b, gate_a} ^ active_low;
    // Legs are A-B and C-D; both on at once means shoot-through
    assign shoot_w = (on_w[0] & on_w[1]) | (on_w[2] & on_w[3]);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            overlaps <= 16'h0000;
        end else if (shoot_w) begin
            overlaps <= overlaps + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int SETTLE = 7;
    localparam int LIMIT = 6000;
    logic clock, reset_n, hsel, hwrite;
    logic [31:0] haddr, hwdata, rdv;
    logic [1:0] htrans, shut_q;
    logic [2:0] hsize;
    logic [7:0] data_q;
    wire logic hreadyout, hresp, out_a, out_b, out_c, out_d;
    wire logic [31:0] hrdata;
    wire logic [3:0] outs;
    wire logic [15:0] overlaps;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;

    assign outs = {out_a, out_b, out_c, out_d};

    cwu_top cwu_top_i (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .data_sources(data_q), .shutdown_sources(shut_q), .drive_output_first(out_a),
        .drive_output_second(out_b), .drive_output_third(out_c),
        .drive_output_fourth(out_d));

    cwu_switch_model cwu_switch_model_i (.clock(clock), .reset_n(reset_n), .gate_a(out_a),
        .gate_b(out_b), .gate_c(out_c), .gate_d(out_d), .active_low(4'h0),
        .overlaps(overlaps));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(rdv & m, e);
    endtask

    task automatic ctl(input logic [2:0] mode, input logic en);
        ahb(1'b1, cwu_pkg::ADDR_CTRL, {25'h0, mode, 3'h0, en});
    endtask

    task automatic cfg(input logic [3:0] pol, input logic [3:0] str, input logic [3:0] ovr,
                       input logic [2:0] ism);
        ahb(1'b1, cwu_pkg::ADDR_OUTCFG, {5'h0, ism, 4'h0, ovr, 4'h0, str, 4'h0, pol});
    endtask

    // Drive the data inputs, let them cross the input filter, compare {A,B,C,D}
    task automatic st(input logic [7:0] d, input logic [3:0] e, input logic [3:0] m = 4'hf);
        @(posedge clock);
        data_q <= d;
        repeat (SETTLE) @(posedge clock);
        check({28'h0, outs & m}, {28'h0, e});
    endtask

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        data_q = 8'h00;
        shut_q = 2'h0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        check({28'h0, outs}, 32'h0);
        rd(cwu_pkg::ADDR_CTRL, 32'hffffffff, 32'h0);
        ahb(1'b1, 8'h20, 32'hffffffff);
        rd(8'h20, 32'hffffffff, 32'h0);
        cfg(4'h0, 4'h0, 4'h0, 3'h0);
        ctl(cwu_pkg::MODE_HALF, 1'b1);
        rd(cwu_pkg::ADDR_CTRL, 32'hffffffff, 32'h41);
        st(8'h01, 4'ha);
        st(8'h00, 4'h5);
        for (int i = 1; i < 8; i++) begin
            cfg(4'h0, 4'h0, 4'h0, i[2:0]);
            st(8'h01 << i, 4'ha);
            st(8'h00, 4'h5);
        end
        cfg(4'h0, 4'h0, 4'hf, 3'h0);
        st(8'h01, 4'ha);
        st(8'h00, 4'h5);
        ahb(1'b1, cwu_pkg::ADDR_DBAND, 32'h00030505);
        st(8'h01, 4'h0, 4'hc);
        st(8'h01, 4'ha);
        st(8'h00, 4'h0, 4'hc);
        st(8'h00, 4'h5);
        ahb(1'b1, cwu_pkg::ADDR_DBAND, 32'h0);
        ahb(1'b1, cwu_pkg::ADDR_SHUT, 32'h20);
        shut_q <= 2'h2;
        st(8'h01, 4'h0);
        rd(cwu_pkg::ADDR_SHUT, 32'h1, 32'h1);
        shut_q <= 2'h0;
        // Let the source drop through the input filter, or it wins over the clear
        repeat (SETTLE) @(posedge clock);
        ahb(1'b1, cwu_pkg::ADDR_SHUT, 32'h0);
        st(8'h01, 4'ha);
        st(8'h00, 4'h5);
        ctl(cwu_pkg::MODE_PUSH, 1'b0);
        rd(cwu_pkg::ADDR_STAT, 32'h10, 32'h10);
        ctl(cwu_pkg::MODE_PUSH, 1'b1);
        st(8'h01, 4'ha);
        st(8'h00, 4'h0);
        st(8'h01, 4'h5);
        st(8'h00, 4'h0);
        ctl(cwu_pkg::MODE_PUSH, 1'b0);
        ctl(cwu_pkg::MODE_PUSH, 1'b1);
        st(8'h01, 4'ha);
        st(8'h00, 4'h0);
        ahb(1'b1, cwu_pkg::ADDR_SHUT, 32'h1);
        ahb(1'b1, cwu_pkg::ADDR_SHUT, 32'h0);
        st(8'h01, 4'ha);
        st(8'h00, 4'h0);
        cfg(4'h0, 4'hf, 4'h0, 3'h0);
        st(8'h01, 4'h5);
        st(8'h00, 4'h0);
        ctl(cwu_pkg::MODE_PUSH, 1'b0);
        ctl(cwu_pkg::MODE_FWD, 1'b1);
        st(8'h01, 4'h9);
        st(8'h00, 4'h8);
        ctl(cwu_pkg::MODE_REV, 1'b1);
        st(8'h00, 4'h8);
        st(8'h01, 4'h6);
        st(8'h00, 4'h2);
        ctl(cwu_pkg::MODE_REV, 1'b0);
        cfg(4'h0, 4'h1, 4'h4, 3'h0);
        ctl(cwu_pkg::MODE_ASTEER, 1'b1);
        st(8'h01, 4'ha);
        st(8'h00, 4'h2);
        ctl(cwu_pkg::MODE_ASTEER, 1'b0);
        ctl(cwu_pkg::MODE_SSTEER, 1'b1);
        st(8'h01, 4'ha);
        st(8'h00, 4'h2);
        ctl(cwu_pkg::MODE_SSTEER, 1'b0);
        ctl(3'h6, 1'b1);
        st(8'h01, 4'h0);
        ctl(3'h6, 1'b0);
        check({16'h0, overlaps}, 32'h0);
        cfg(4'hc, 4'h0, 4'h0, 3'h0);
        st(8'h00, 4'h3);
        ctl(cwu_pkg::MODE_HALF, 1'b1);
        st(8'h01, 4'h9);
        give_verdict();
    end
endmodule
`default_nettype wire
